// *** usr_pkg.sv ***
package usr_pkg;
    // clock and timing
    localparam int CLK_FREQ_MHZ      = 20;
    localparam int SUSP_IDLE_US      = 3000;
    localparam int SUSP_IDLE_CYCLES  = SUSP_IDLE_US * CLK_FREQ_MHZ;
    localparam int STAB_CYCLES_DEF   = 256;
    localparam int TIMER_W           = 20;

    // bus shape
    localparam int ADDR_W            = 18;
    localparam int DATA_W            = 32;

    // register indices, byte address is four times the index
    localparam logic [15:0] CTRL_STAT_IDX = 16'h7fd6;
    localparam logic [15:0] PWR_CTRL_IDX  = 16'h7fd0;
    localparam logic [15:0] IRQ_STAT_IDX  = 16'h7fd1;
    localparam logic [15:0] IRQ_MASK_IDX  = 16'h7fd2;
    localparam logic [15:0] CFG_ATTR_IDX  = 16'h7fd3;
    localparam logic [15:0] LINK_STAT_IDX = 16'h7fd4;

    // usb control/status fields
    localparam int CS_WAKE_SRC  = 7;
    localparam int CS_DISC      = 3;
    localparam int CS_DISC_OE   = 2;
    localparam int CS_PERS      = 1;
    localparam int CS_SIG_RES   = 0;
    localparam logic [7:0] CTRL_STAT_RST   = 8'h00;
    localparam logic [7:0] CTRL_STAT_WMASK = 8'h0f;

    // power control field
    localparam int PWR_IDLE     = 0;

    // interrupt status and mask fields
    localparam int IRQ_SUSP     = 0;
    localparam int IRQ_RES      = 1;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] IRQ_USED     = 8'h03;

    // configuration attribute byte
    localparam int ATTR_RWU     = 5;
    localparam int ATTR_BYTE_POS = 7;
    localparam logic [7:0] ATTR_RST     = 8'h80;
    localparam logic [7:0] ATTR_WMASK   = 8'h20;

    // device feature selector for remote wakeup
    localparam logic [7:0] FEAT_REMOTE_WAKEUP = 8'h01;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_PEND,
        ST_SUSP,
        ST_STAB
    } usr_state_t;

    function automatic logic [ADDR_W-1:0] usr_byte_addr(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction
endpackage

// *** usr_cycle_timer.sv ***
`timescale 1ns/1ps
module usr_cycle_timer #(
    parameter int WIDTH = 20
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             run_i,
    input  wire logic [WIDTH-1:0] limit_i,
    output logic                  done_o
);
    logic [WIDTH-1:0] cnt_q;

    // counts while run until done and holds there, restarts whenever run drops
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !run_i) begin
            cnt_q <= '0;
        end else if (!done_o) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign done_o = run_i && (cnt_q == limit_i - 1'b1);
endmodule

// *** usr_suspend_ctrl.sv ***
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// Behaviour
// - three milliseconds of continuous idle J on the bus means suspend.
// - on suspend raise usb interrupt line, oscillator stays running.
// - idle request is bit 0 of power control; the resume interrupt or a write of 0 to it ends idle.
// - idle request bit stops oscillator and pll, entering low-power suspend.
// - oscillator restarts on bus activity or wake pin driven low.
// - after stabilization wait, assert resume interrupt, ending processor idle.
// - resume interrupt has top priority and ignores any enable or mask.
// - resume interrupt only once clock has restarted; sole resume completion path.
// - wake source flag reads 1 for pin, 0 for bus; write 1 clears.
// - wake pin held low prevents suspend; unused designs tie it high.
// - signal-resume bit high forces K on the bus; low restores normal buffer; this design forces K only while remote wakeup is allowed.
// - control/status: b7 wake src, b3 disc, b2 disc oe, b1 personality, b0 resume.
// - default configuration attribute byte, position 7, reports no remote wakeup.
// - remote wakeup needs advertised capability and host set_feature selector 0x01.
// - suspended state holds, oscillator off, until bus activity or wake pin.
module usr_suspend_ctrl
    import usr_pkg::*;
#(
    parameter int SUSP_CYCLES = usr_pkg::SUSP_IDLE_CYCLES,
    parameter int STAB_CYCLES = usr_pkg::STAB_CYCLES_DEF
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_i,
    input  wire logic [usr_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [usr_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]                 avs_byteenable_i,
    output logic [usr_pkg::DATA_W-1:0]      avs_readdata_o,
    output logic                            avs_waitrequest_o,
    input  wire logic                       bus_j_idle_i,
    input  wire logic                       wake_n_i,
    input  wire logic                       set_feature_i,
    input  wire logic                       clear_feature_i,
    input  wire logic [7:0]                 feature_sel_i,
    output logic                            osc_run_o,
    output logic                            cpu_idle_o,
    output logic                            usb_interrupt_line_o,
    output logic                            resume_int_o,
    output logic                            irq_o,
    output logic                            force_k_o,
    output logic                            disconnect_o,
    output logic                            disconnect_oe_o,
    output logic                            personality_o,
    output logic [7:0]                      cfg_attr_o,
    output logic                            rwu_allowed_o
);
    import usr_pkg::*;

    localparam logic [TIMER_W-1:0] SUSP_LIMIT = TIMER_W'(SUSP_CYCLES);
    localparam logic [TIMER_W-1:0] STAB_LIMIT = TIMER_W'(STAB_CYCLES);

    usr_state_t  state_q;
    usr_state_t  state_d;
    logic [7:0]  ctrl_stat_q;
    logic [7:0]  pwr_q;
    logic [7:0]  stat_q;
    logic [7:0]  stat_d;
    logic [7:0]  mask_q;
    logic [7:0]  attr_q;
    logic        host_rwu_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        osc_q;
    logic        usb_int_q;
    logic        res_int_q;
    logic        irq_q;
    logic        force_k_q;
    logic        rwu_ok_q;
    logic        susp_done;
    logic        stab_done;
    logic        idle_idle_run;
    logic        req;
    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic        lane0;
    logic [7:0]  wbyte;
    logic        set_susp;
    logic        set_res;
    logic        set_wake_src;
    logic        leave_susp;

    // bus slave handshake
    assign req    = avs_read_i || avs_write_i;
    assign acc    = req && !wait_q;
    assign wr_acc = acc && avs_write_i;
    assign rd_acc = acc && avs_read_i;
    assign lane0  = avs_byteenable_i[0];
    assign wbyte  = avs_writedata_i[7:0];

    function automatic logic hit(input logic [15:0] idx);
        return avs_address_i == usr_byte_addr(idx);
    endfunction

    function automatic logic wr_hit(input logic [15:0] idx);
        return wr_acc && lane0 && hit(idx);
    endfunction

    function automatic logic rwu_sel(input logic [7:0] sel);
        return sel == FEAT_REMOTE_WAKEUP;
    endfunction

    // idle J timer, held off by a low wake pin
    assign idle_idle_run = (state_q == ST_RUN) && bus_j_idle_i && wake_n_i;

    usr_cycle_timer #(
        .WIDTH (TIMER_W)
    ) u_susp_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (idle_idle_run),
        .limit_i   (SUSP_LIMIT),
        .done_o    (susp_done)
    );

    // stabilization wait after restart
    usr_cycle_timer #(
        .WIDTH (TIMER_W)
    ) u_stab_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (state_q == ST_STAB),
        .limit_i   (STAB_LIMIT),
        .done_o    (stab_done)
    );

    assign set_susp     = susp_done;
    assign set_res      = (state_q == ST_STAB) && stab_done;
    assign leave_susp   = (state_q == ST_SUSP) && (!bus_j_idle_i || !wake_n_i);
    assign set_wake_src = leave_susp && !wake_n_i;

    // suspend state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (pwr_q[PWR_IDLE] && wake_n_i) begin
                    state_d = ST_SUSP;
                end else if (susp_done) begin
                    state_d = ST_PEND;
                end
            end
            ST_PEND: begin
                if (pwr_q[PWR_IDLE] && wake_n_i) begin
                    state_d = ST_SUSP;
                end else if (!bus_j_idle_i) begin
                    state_d = ST_RUN;
                end
            end
            ST_SUSP: begin
                if (leave_susp) begin
                    state_d = ST_STAB;
                end
            end
            ST_STAB: begin
                if (stab_done) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // oscillator and pll run except while suspended; they run during the stabilization wait
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            osc_q <= 1'b1;
        end else begin
            osc_q <= (state_d != ST_SUSP);
        end
    end

    // power control: idle request, ended by the resume interrupt
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pwr_q <= 8'h00;
        end else if (set_res) begin
            pwr_q[PWR_IDLE] <= 1'b0;
        end else if (wr_hit(PWR_CTRL_IDX)) begin
            pwr_q[PWR_IDLE] <= wbyte[PWR_IDLE];
        end
    end

    // usb control/status
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_stat_q <= CTRL_STAT_RST;
        end else begin
            if (wr_hit(CTRL_STAT_IDX)) begin
                ctrl_stat_q[3:0] <= wbyte[3:0] & CTRL_STAT_WMASK[3:0];
                if (wbyte[CS_WAKE_SRC]) begin
                    ctrl_stat_q[CS_WAKE_SRC] <= 1'b0;
                end
            end
            if (set_wake_src) begin
                ctrl_stat_q[CS_WAKE_SRC] <= 1'b1;
            end
        end
    end

    // sticky interrupt status, a read clears, a new event wins
    always_comb begin
        stat_d = stat_q;
        if (rd_acc && hit(IRQ_STAT_IDX)) begin
            stat_d = 8'h00;
        end
        if (set_susp) begin
            stat_d[IRQ_SUSP] = 1'b1;
        end
        if (set_res) begin
            stat_d[IRQ_RES] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            stat_q <= 8'h00;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mask_q <= IRQ_MASK_RST;
        end else if (wr_hit(IRQ_MASK_IDX)) begin
            mask_q <= wbyte & IRQ_USED;
        end
    end

    // interrupt outputs; resume bypasses the mask
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            usb_int_q <= 1'b0;
        end else begin
            usb_int_q <= stat_d[IRQ_SUSP] && mask_q[IRQ_SUSP];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            res_int_q <= 1'b0;
        end else begin
            res_int_q <= stat_d[IRQ_RES];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= stat_d[IRQ_RES] || |(stat_d & mask_q);
        end
    end

    // configuration attribute byte, no remote wakeup by default
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            attr_q <= ATTR_RST;
        end else if (wr_hit(CFG_ATTR_IDX)) begin
            attr_q <= ATTR_RST | (wbyte & ATTR_WMASK);
        end
    end

    // host enable of remote wakeup
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            host_rwu_q <= 1'b0;
        end else if (set_feature_i && rwu_sel(feature_sel_i)) begin
            host_rwu_q <= 1'b1;
        end else if (clear_feature_i && rwu_sel(feature_sel_i)) begin
            host_rwu_q <= 1'b0;
        end
    end

    // K drive only while signalling resume and remote wakeup allowed
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rwu_ok_q <= 1'b0;
        end else begin
            rwu_ok_q <= attr_q[ATTR_RWU] && host_rwu_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            force_k_q <= 1'b0;
        end else begin
            force_k_q <= ctrl_stat_q[CS_SIG_RES] && attr_q[ATTR_RWU] && host_rwu_q;
        end
    end

    // bus slave: one wait cycle, answer at the second edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(req && wait_q);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (req && wait_q && avs_read_i) begin
            if (hit(CTRL_STAT_IDX)) begin
                rdata_q <= {24'h00_0000, ctrl_stat_q};
            end else if (hit(PWR_CTRL_IDX)) begin
                rdata_q <= {24'h00_0000, pwr_q};
            end else if (hit(IRQ_STAT_IDX)) begin
                rdata_q <= {24'h00_0000, stat_q};
            end else if (hit(IRQ_MASK_IDX)) begin
                rdata_q <= {24'h00_0000, mask_q};
            end else if (hit(CFG_ATTR_IDX)) begin
                rdata_q <= {24'h00_0000, attr_q};
            end else if (hit(LINK_STAT_IDX)) begin
                rdata_q <= {28'h000_0000, rwu_ok_q, osc_q, 2'(state_q)};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    assign avs_readdata_o       = rdata_q;
    assign avs_waitrequest_o    = wait_q;
    assign osc_run_o            = osc_q;
    assign cpu_idle_o           = pwr_q[PWR_IDLE];
    assign usb_interrupt_line_o = usb_int_q;
    assign resume_int_o         = res_int_q;
    assign irq_o                = irq_q;
    assign force_k_o            = force_k_q;
    assign disconnect_o         = ctrl_stat_q[CS_DISC];
    assign disconnect_oe_o      = ctrl_stat_q[CS_DISC_OE];
    assign personality_o        = ctrl_stat_q[CS_PERS];
    assign cfg_attr_o           = attr_q;
    assign rwu_allowed_o        = rwu_ok_q;
endmodule

// *** usr_suspend_ctrl_properties.sv ***
`timescale 1ns/1ps
module usr_suspend_ctrl_properties #(
    parameter int SUSP_CYCLES = 50,
    parameter int STAB_CYCLES = 8
) (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       avs_read_i,
    input wire logic       avs_write_i,
    input wire logic       avs_waitrequest_o,
    input wire logic       bus_j_idle_i,
    input wire logic       wake_n_i,
    input wire logic       osc_run_o,
    input wire logic       cpu_idle_o,
    input wire logic       resume_int_o,
    input wire logic       irq_o,
    input wire logic       force_k_o,
    input wire logic       rwu_allowed_o,
    input wire logic [7:0] cfg_attr_o
);
    localparam int STAB_LO = STAB_CYCLES - 1;
    localparam int STAB_HI = STAB_CYCLES + 3;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_wait_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    property p_osc_off; $fell(osc_run_o) |-> $past(cpu_idle_o); endproperty
    property p_hold; !osc_run_o && wake_n_i && bus_j_idle_i |=> !osc_run_o; endproperty
    property p_wake; !osc_run_o && !(wake_n_i && bus_j_idle_i) |=> osc_run_o; endproperty
    property p_res_clk; $rose(resume_int_o) |-> osc_run_o && $past(osc_run_o, 2); endproperty
    property p_res_idle; $rose(resume_int_o) |-> !cpu_idle_o; endproperty
    property p_res_irq; resume_int_o |-> irq_o; endproperty
    property p_stab; $rose(osc_run_o) |-> ##[STAB_LO:STAB_HI] $rose(resume_int_o); endproperty
    property p_k; force_k_o |-> rwu_allowed_o; endproperty
    property p_attr; $fell(rst_i) |-> cfg_attr_o == 8'h80; endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    a_osc_off: assert property (p_osc_off) else $error("oscillator stopped unasked");
    a_hold: assert property (p_hold) else $error("left suspend without cause");
    a_wake: assert property (p_wake) else $error("oscillator not restarted");
    a_res_clk: assert property (p_res_clk) else $error("resume before clock");
    a_res_idle: assert property (p_res_idle) else $error("idle not ended");
    a_res_irq: assert property (p_res_irq) else $error("resume interrupt masked");
    a_stab: assert property (p_stab) else $error("stabilization count wrong");
    a_k: assert property (p_k) else $error("k forced without permission");
    a_attr: assert property (p_attr) else $error("attribute byte reset wrong");
    c_susp: cover property ($fell(osc_run_o));
    c_res: cover property ($rose(resume_int_o));
    c_k: cover property ($rose(force_k_o));
endmodule

// *** usr_host_model.sv ***
`timescale 1ns/1ps
module usr_host_model (
    input  wire logic sys_clk_i,
    input  wire logic active_i,
    input  wire logic force_k_i,
    output logic       bus_j_idle_o,
    output logic       set_feature_o,
    output logic       clear_feature_o,
    output logic [7:0] feature_sel_o
);
    // k on the wire is not idle j
    assign bus_j_idle_o = !active_i && !force_k_i;
    initial begin
        set_feature_o = 1'b0;
        clear_feature_o = 1'b0;
        feature_sel_o = 8'h00;
    end
    task send_feature(input logic set, input logic [7:0] sel);
        @(posedge sys_clk_i);
        set_feature_o <= set;
        clear_feature_o <= !set;
        feature_sel_o <= sel;
        @(posedge sys_clk_i);
        set_feature_o <= 1'b0;
        clear_feature_o <= 1'b0;
        feature_sel_o <= ~sel;
    endtask
endmodule

// *** usr_suspend_resume_wakeup_test.sv ***
`timescale 1ns/1ps
module usr_suspend_resume_wakeup_test;
    import usr_pkg::*;
    logic sys_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, bus_j_idle_i;
    logic wake_n_i, set_feature_i, clear_feature_i, osc_run_o, cpu_idle_o, irq_o;
    logic usb_interrupt_line_o, resume_int_o, force_k_o, rwu_allowed_o, host_active;
    logic disconnect_o, disconnect_oe_o, personality_o;
    logic [ADDR_W-1:0] avs_address_i;
    logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o, q;
    logic [3:0]        avs_byteenable_i;
    logic [7:0]        feature_sel_i, cfg_attr_o;
    int                mismatches, cmp_count;
    usr_suspend_ctrl #(.SUSP_CYCLES(50), .STAB_CYCLES(8)) u_dut (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .bus_j_idle_i(bus_j_idle_i),
        .wake_n_i(wake_n_i), .set_feature_i(set_feature_i),
        .clear_feature_i(clear_feature_i), .feature_sel_i(feature_sel_i),
        .osc_run_o(osc_run_o), .cpu_idle_o(cpu_idle_o),
        .usb_interrupt_line_o(usb_interrupt_line_o), .resume_int_o(resume_int_o),
        .irq_o(irq_o), .force_k_o(force_k_o), .disconnect_o(disconnect_o),
        .disconnect_oe_o(disconnect_oe_o), .personality_o(personality_o),
        .cfg_attr_o(cfg_attr_o), .rwu_allowed_o(rwu_allowed_o));
    usr_host_model u_host (.sys_clk_i(sys_clk_i), .active_i(host_active),
        .force_k_i(force_k_o), .bus_j_idle_o(bus_j_idle_i),
        .set_feature_o(set_feature_i), .clear_feature_o(clear_feature_i),
        .feature_sel_o(feature_sel_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task timed_out;
        mismatches++;
        $display("unexpected at %0t: wait ran out", $time);
        end_of_test();
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        int n;
        @(posedge sys_clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 20) timed_out();
    endtask
    task rdc(input logic [15:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask
    task wait_res;
        int n;
        n = 0;
        while (resume_int_o !== 1'b1 && n < 100) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 100) timed_out();
    endtask
    task test_regs;
        rdc(CTRL_STAT_IDX, 32'h0);
        rdc(CFG_ATTR_IDX, 32'h80);
        chk(cfg_attr_o, 8'h80);
        rdc(LINK_STAT_IDX, 32'h4);
        rdc(16'h7fdf, 32'h0);
        bus(1'b1, CTRL_STAT_IDX, 8'hff);
        rdc(CTRL_STAT_IDX, 32'h0f);
        chk({disconnect_o, disconnect_oe_o, personality_o}, 3'b111);
        chk(force_k_o, 1'b0);
        avs_byteenable_i <= 4'h0;
        bus(1'b1, CTRL_STAT_IDX, 8'h00);
        avs_byteenable_i <= 4'h1;
        rdc(CTRL_STAT_IDX, 32'h0f);
        bus(1'b1, CTRL_STAT_IDX, 8'h00);
        $display("test regs done");
    endtask
    task test_suspend;
        wake_n_i <= 1'b0;
        bus(1'b1, IRQ_MASK_IDX, 8'h01);
        tick(70);
        chk(usb_interrupt_line_o, 1'b0);
        wake_n_i <= 1'b1;
        tick(40);
        chk(usb_interrupt_line_o, 1'b0);
        tick(20);
        chk(usb_interrupt_line_o, 1'b1);
        chk(osc_run_o, 1'b1);
        rdc(IRQ_STAT_IDX, 32'h1);
        tick(2);
        chk(usb_interrupt_line_o, 1'b0);
        $display("test suspend done");
    endtask
    task test_bus_resume;
        bus(1'b1, PWR_CTRL_IDX, 8'h01);
        tick(2);
        chk(osc_run_o, 1'b0);
        chk(cpu_idle_o, 1'b1);
        tick(20);
        chk(osc_run_o, 1'b0);
        host_active <= 1'b1;
        wait_res();
        chk(cpu_idle_o, 1'b0);
        chk(irq_o, 1'b1);
        rdc(CTRL_STAT_IDX, 32'h0);
        rdc(IRQ_STAT_IDX, 32'h2);
        $display("test bus resume done");
    endtask
    task test_remote_wake;
        bus(1'b1, CFG_ATTR_IDX, 8'h20);
        u_host.send_feature(1'b1, FEAT_REMOTE_WAKEUP);
        tick(2);
        chk(rwu_allowed_o, 1'b1);
        host_active <= 1'b0;
        bus(1'b1, PWR_CTRL_IDX, 8'h01);
        tick(3);
        chk(osc_run_o, 1'b0);
        wake_n_i <= 1'b0;
        wait_res();
        wake_n_i <= 1'b1;
        rdc(CTRL_STAT_IDX, 32'h80);
        rdc(IRQ_STAT_IDX, 32'h2);
        bus(1'b1, CTRL_STAT_IDX, 8'h01);
        tick(2);
        chk(force_k_o, 1'b1);
        bus(1'b1, CTRL_STAT_IDX, 8'h80);
        tick(2);
        chk(force_k_o, 1'b0);
        rdc(CTRL_STAT_IDX, 32'h0);
        u_host.send_feature(1'b0, FEAT_REMOTE_WAKEUP);
        tick(2);
        chk(rwu_allowed_o, 1'b0);
        $display("test remote wake done");
    endtask
    initial begin
        mismatches = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        avs_address_i = '0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = '0;
        avs_byteenable_i = 4'h1;
        wake_n_i = 1'b1;
        host_active = 1'b1;
        tick(12);
        rst_i <= 1'b0;
        tick(1);
        test_regs();
        host_active <= 1'b0;
        test_suspend();
        test_bus_resume();
        test_remote_wake();
        end_of_test();
    end
endmodule
bind usr_suspend_ctrl usr_suspend_ctrl_properties #(.SUSP_CYCLES(SUSP_CYCLES),
    .STAB_CYCLES(STAB_CYCLES)) u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .bus_j_idle_i(bus_j_idle_i),
    .wake_n_i(wake_n_i), .osc_run_o(osc_run_o), .cpu_idle_o(cpu_idle_o),
    .resume_int_o(resume_int_o), .irq_o(irq_o), .force_k_o(force_k_o),
    .rwu_allowed_o(rwu_allowed_o), .cfg_attr_o(cfg_attr_o));
